// [pms_mode_seq.sv]
// processor operating-mode sequencer with an axi4-lite register slave
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

module pms_mode_seq
    import pms_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        mgmt_interrupt_pin_n,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output pms_mode_e        mode_reg,
    output logic             mgmt_space_reg,
    output logic             identity_map_reg
);

    // ****************************************
    // state
    // ****************************************
    logic [31:0] ctrl_reg;        // control word zero
    logic [31:0] efer_reg;        // extended feature enable
    logic [31:0] flags_reg;       // flags word
    logic        cs_long_reg;     // long bit of code segment
    logic [31:0] root_reg;        // paging root low word
    logic [PMS_PRIO_W-1:0] prio_reg; // task priority
    pms_ctx_s    save_reg;        // context saved on entry
    pms_width_s  width_reg;       // width summary
    logic [2:0]  pin_sync_reg;    // two-stage sync plus history
    logic        mgmt_pend_reg;   // latched management request
    logic        aw_got_reg;      // address captured
    logic        w_got_reg;       // data captured
    logic [7:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        resume_req;      // resume strobe
    logic        wr_fire;         // write both halves present
    logic        mgmt_edge;       // new falling edge on the pin
    pms_mode_e   mode_next;

    // byte-lane merge used by the control, flags and root registers
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // mode a control set implies, outside management mode
    function automatic pms_mode_e decode_mode(input logic [31:0] c,
                                              input logic [31:0] e,
                                              input logic [31:0] f,
                                              input logic        csl);
        pms_mode_e m;
        m = PMS_REAL;
        if (e[PMS_LONG_ACT_BIT]) begin
            m = csl ? PMS_WIDE : PMS_COMPAT;
        end else if (c[PMS_PROT_EN_BIT]) begin
            m = f[PMS_VIRT_BIT] ? PMS_V86 : PMS_PROT;
        end
        return m;
    endfunction

    // ****************************************
    // management pin synchroniser
    // ****************************************
    // active-low pin passes two flops; edge taken from stages two and three
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_sync_reg <= 3'b111;
        end else begin
            pin_sync_reg <= {pin_sync_reg[1:0], mgmt_interrupt_pin_n};
        end
    end
    assign mgmt_edge = pin_sync_reg[2] & ~pin_sync_reg[1];

    // pending request; a new edge wins over the clear on entry
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mgmt_pend_reg <= 1'b0;
        end else if (mgmt_edge) begin
            mgmt_pend_reg <= 1'b1;
        end else if (mode_reg != PMS_MGMT) begin
            mgmt_pend_reg <= 1'b0;                      // taken this cycle
        end
    end

    // ****************************************
    // axi4-lite write channel
    // ****************************************
    assign wr_fire = aw_got_reg & w_got_reg & ~s_axi_bvalid;
    assign resume_req = wr_fire & (awaddr_reg == PMS_RESUME_OFF);

    // address and data accepted in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg    <= 1'b0;
            w_got_reg     <= 1'b0;
            awaddr_reg    <= 8'h00;
            wdata_reg     <= PMS_ZERO32;
            wstrb_reg     <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= PMS_RESP_OK;
        end else begin
            s_axi_awready <= ~aw_got_reg & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_got_reg & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_reg   <= 1'b0;
                w_got_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // read-only and unmapped words answer slave error
                case (awaddr_reg)
                    PMS_CTRL_OFF, PMS_EFER_OFF, PMS_FLAGS_OFF,
                    PMS_CSEG_OFF, PMS_ROOT_OFF, PMS_PRIO_OFF,
                    PMS_RESUME_OFF: s_axi_bresp <= PMS_RESP_OK;
                    default:     s_axi_bresp <= PMS_RESP_ERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // architectural control registers
    // ****************************************
    // resume restores the saved words; otherwise software writes land
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg    <= PMS_ZERO32;
            efer_reg    <= PMS_ZERO32;
            flags_reg   <= PMS_ZERO32;
            cs_long_reg <= 1'b0;
            root_reg    <= PMS_ZERO32;
            prio_reg    <= '0;
        end else if (resume_req && mode_reg == PMS_MGMT) begin
            ctrl_reg  <= save_reg.ctrl;
            flags_reg <= save_reg.flags;
            efer_reg  <= save_reg.efer;
        end else if (wr_fire) begin
            case (awaddr_reg)
                PMS_CTRL_OFF: begin
                    ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg);
                end
                PMS_EFER_OFF: begin
                    // active bit is hardware owned, not writable
                    efer_reg[PMS_LONG_EN_BIT] <= wstrb_reg[1] ?
                        wdata_reg[PMS_LONG_EN_BIT] :
                        efer_reg[PMS_LONG_EN_BIT];
                end
                PMS_FLAGS_OFF: begin
                    flags_reg <= merge(flags_reg, wdata_reg, wstrb_reg);
                    // keyed on the active bit so the step into long is covered
                    if (efer_reg[PMS_LONG_ACT_BIT]) begin
                        flags_reg[PMS_VIRT_BIT] <= 1'b0;
                    end
                end
                PMS_CSEG_OFF: begin
                    if (wstrb_reg[0]) begin
                        cs_long_reg <= wdata_reg[PMS_CSL_BIT];
                    end
                end
                PMS_ROOT_OFF: begin
                    root_reg <= merge(root_reg, wdata_reg, wstrb_reg);
                end
                PMS_PRIO_OFF: begin
                    // window only reachable in long mode
                    if ((mode_reg == PMS_WIDE || mode_reg == PMS_COMPAT)
                        && wstrb_reg[0]) begin
                        prio_reg <= wdata_reg[PMS_PRIO_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end else begin
            // long activates only from protected with paging and enable
            if (!efer_reg[PMS_LONG_ACT_BIT] && mode_reg == PMS_PROT
                && ctrl_reg[PMS_PG_BIT] && efer_reg[PMS_LONG_EN_BIT]) begin
                efer_reg[PMS_LONG_ACT_BIT] <= 1'b1;
            end else if (efer_reg[PMS_LONG_ACT_BIT] && mode_reg != PMS_MGMT
                && !ctrl_reg[PMS_PG_BIT]) begin
                efer_reg[PMS_LONG_ACT_BIT] <= 1'b0;
            end
        end
    end

    // ****************************************
    // mode sequencer
    // ****************************************
    // management entry beats any other change; resume reloads saved mode
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            PMS_REAL, PMS_PROT, PMS_V86, PMS_COMPAT, PMS_WIDE: begin
                if (mgmt_pend_reg) begin
                    mode_next = PMS_MGMT;
                end else begin
                    mode_next = decode_mode(ctrl_reg, efer_reg,
                                            flags_reg, cs_long_reg);
                end
            end
            PMS_MGMT: begin
                if (resume_req) begin
                    mode_next = save_reg.mode;
                end
            end
            default: mode_next = PMS_REAL;
        endcase
        // virtual mode never straight from real; step through protected
        if (mode_reg == PMS_REAL && mode_next == PMS_V86) begin
            mode_next = PMS_PROT;
        end
    end

    // one registered mode value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= PMS_REAL;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // context capture and separate space on entry
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            save_reg       <= '{mode: PMS_REAL, default: '0};
            mgmt_space_reg <= 1'b0;
        end else if (mode_reg != PMS_MGMT && mode_next == PMS_MGMT) begin
            save_reg.mode  <= mode_reg;
            save_reg.ctrl  <= ctrl_reg;
            save_reg.flags <= flags_reg;
            save_reg.efer  <= efer_reg;
            mgmt_space_reg <= 1'b1;
        end else if (mode_reg == PMS_MGMT && mode_next != PMS_MGMT) begin
            mgmt_space_reg <= 1'b0;
        end
    end

    // ****************************************
    // width and translation summary
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            width_reg        <= '{idt_bytes: PMS_IDT_LEG,
                                  reg_width: PMS_W32,
                                  dbg_width: PMS_W32,
                                  levels:    PMS_LVL_NONE,
                                  task_gate: 1'b1,
                                  prio_en:   1'b0,
                                  ident_map: 1'b1,
                                  pad:       2'h0};
            identity_map_reg <= 1'b1;
        end else begin
            if (mode_next == PMS_WIDE || mode_next == PMS_COMPAT) begin
                width_reg.idt_bytes <= PMS_IDT_LONG;
                width_reg.reg_width <= PMS_W64;
                width_reg.dbg_width <= PMS_W64;
                width_reg.levels    <= PMS_LVL_LONG;
                width_reg.task_gate <= 1'b0;
                width_reg.prio_en   <= 1'b1;
            end else if (mode_next != PMS_MGMT) begin
                width_reg.idt_bytes <= PMS_IDT_LEG;
                width_reg.reg_width <= PMS_W32;
                width_reg.dbg_width <= PMS_W32;
                width_reg.levels    <= ctrl_reg[PMS_PG_BIT] ?
                                       PMS_LVL_LEG : PMS_LVL_NONE;
                width_reg.task_gate <= 1'b1;
                width_reg.prio_en   <= 1'b0;
            end
            width_reg.ident_map <= ~ctrl_reg[PMS_PG_BIT];
            identity_map_reg    <= ~ctrl_reg[PMS_PG_BIT];
        end
    end

    // ****************************************
    // axi4-lite read channel
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= PMS_ZERO32;
            s_axi_rresp   <= PMS_RESP_OK;
        end else begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= PMS_RESP_OK;
                case (s_axi_araddr)
                    PMS_CTRL_OFF:  s_axi_rdata <= ctrl_reg;
                    PMS_EFER_OFF:  s_axi_rdata <= efer_reg;
                    PMS_FLAGS_OFF: s_axi_rdata <= flags_reg;
                    PMS_CSEG_OFF:  s_axi_rdata <= {31'h0, cs_long_reg};
                    PMS_MODE_OFF:  s_axi_rdata <= {29'h0, mode_reg};
                    PMS_ROOT_OFF:  s_axi_rdata <= root_reg;
                    PMS_PRIO_OFF:  s_axi_rdata <= {28'h0, prio_reg};
                    PMS_WIDTH_OFF: s_axi_rdata <= width_reg;
                    PMS_SAVE_OFF:  s_axi_rdata <= {29'h0, save_reg.mode};
                    PMS_RESUME_OFF: s_axi_rdata <= PMS_ZERO32;
                    default: begin
                        s_axi_rdata <= PMS_ZERO32;
                        s_axi_rresp <= PMS_RESP_ERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence s_pin_fall;
        pin_sync_reg[2] && !pin_sync_reg[1];
    endsequence

    property p_reset_real;
        @(posedge aclk) !aresetn |=> mode_reg == PMS_REAL;
    endproperty
    a_reset_real: assert property (p_reset_real)
        else $error("mode not real after reset");

    property p_mgmt_enter;
        @(posedge aclk) disable iff (!aresetn)
        s_pin_fall ##0 (mode_reg != PMS_MGMT && !resume_req)
            |-> ##[1:2] mode_reg == PMS_MGMT;
    endproperty
    a_mgmt_enter: assert property (p_mgmt_enter)
        else $error("management entry missed");

    property p_save_mode;
        @(posedge aclk) disable iff (!aresetn)
        (mode_reg != PMS_MGMT && mode_next == PMS_MGMT)
            |=> save_reg.mode == $past(mode_reg) && mgmt_space_reg;
    endproperty
    a_save_mode: assert property (p_save_mode)
        else $error("context not saved on entry");

    property p_resume;
        @(posedge aclk) disable iff (!aresetn)
        (mode_reg == PMS_MGMT && resume_req)
            |=> mode_reg == $past(save_reg.mode) && !mgmt_space_reg;
    endproperty
    a_resume: assert property (p_resume)
        else $error("resume went to wrong mode");

    property p_restore;
        @(posedge aclk) disable iff (!aresetn)
        (mode_reg == PMS_MGMT && resume_req)
            |=> ctrl_reg == $past(save_reg.ctrl)
                && flags_reg == $past(save_reg.flags);
    endproperty
    a_restore: assert property (p_restore)
        else $error("state not restored");

    property p_long_entry;
        @(posedge aclk) disable iff (!aresetn)
        $rose(efer_reg[PMS_LONG_ACT_BIT]) |-> $past(mode_reg) == PMS_PROT;
    endproperty
    a_long_entry: assert property (p_long_entry)
        else $error("long mode entered from wrong mode");

    property p_no_v86_long;
        @(posedge aclk) disable iff (!aresetn)
        mode_reg == PMS_WIDE || mode_reg == PMS_COMPAT
            |-> !flags_reg[PMS_VIRT_BIT] || $past(mode_reg) == PMS_MGMT;
    endproperty
    a_no_v86_long: assert property (p_no_v86_long)
        else $error("virtual flag set in long mode");

    property p_long_width;
        @(posedge aclk) disable iff (!aresetn)
        mode_reg == PMS_WIDE |-> width_reg.idt_bytes == PMS_IDT_LONG
            && width_reg.levels == PMS_LVL_LONG && !width_reg.task_gate;
    endproperty
    a_long_width: assert property (p_long_width)
        else $error("long mode widths wrong");

    property p_v86_parent;
        @(posedge aclk) disable iff (!aresetn)
        $changed(mode_reg) && mode_reg == PMS_V86
            |-> $past(mode_reg) inside {PMS_PROT, PMS_V86, PMS_MGMT};
    endproperty
    a_v86_parent: assert property (p_v86_parent)
        else $error("virtual mode entered from real");

endmodule

// [pms_pkg.sv]
// package: constants, enums and carrier structs for the mode sequencer
package pms_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] PMS_CTRL_OFF   = 8'h00; // control word zero
    localparam logic [7:0] PMS_EFER_OFF   = 8'h04; // extended feature enable
    localparam logic [7:0] PMS_FLAGS_OFF  = 8'h08; // flags word
    localparam logic [7:0] PMS_CSEG_OFF   = 8'h0C; // code segment attributes
    localparam logic [7:0] PMS_MODE_OFF   = 8'h10; // current mode, read only
    localparam logic [7:0] PMS_ROOT_OFF   = 8'h14; // paging root, low word
    localparam logic [7:0] PMS_PRIO_OFF   = 8'h18; // priority window
    localparam logic [7:0] PMS_RESUME_OFF = 8'h1C; // resume trigger, write
    localparam logic [7:0] PMS_WIDTH_OFF  = 8'h20; // width summary, read only
    localparam logic [7:0] PMS_SAVE_OFF   = 8'h24; // saved context, read only

    // ****************************************
    // field positions
    // ****************************************
    localparam int PMS_PROT_EN_BIT  = 0;  // protection enable, control zero
    localparam int PMS_PG_BIT       = 31; // paging enable in control zero
    localparam int PMS_LONG_EN_BIT  = 8;  // long mode enable
    localparam int PMS_LONG_ACT_BIT = 10; // long mode active
    localparam int PMS_VIRT_BIT     = 17; // virtual mode flag
    localparam int PMS_CSL_BIT      = 0;  // long bit of code segment
    localparam int PMS_PRIO_W       = 4;  // task priority field width

    // ****************************************
    // reset values and widths
    // ****************************************
    localparam logic [31:0] PMS_ZERO32    = 32'h0000_0000;
    localparam logic [7:0]  PMS_IDT_LONG  = 8'h10; // 16-byte descriptors
    localparam logic [7:0]  PMS_IDT_LEG   = 8'h08; // 8-byte descriptors
    localparam logic [7:0]  PMS_W64       = 8'h40; // 64-bit width
    localparam logic [7:0]  PMS_W32       = 8'h20; // 32-bit width
    localparam logic [2:0]  PMS_LVL_LONG  = 3'h4;  // translation levels
    localparam logic [2:0]  PMS_LVL_LEG   = 3'h2;
    localparam logic [2:0]  PMS_LVL_NONE  = 3'h0;
    localparam logic [1:0]  PMS_RESP_OK   = 2'h0;
    localparam logic [1:0]  PMS_RESP_ERR  = 2'h2;  // slave error

    // ****************************************
    // mode encoding, gray along the usual path
    // ****************************************
    typedef enum logic [2:0] {
        PMS_REAL   = 3'b000,
        PMS_PROT   = 3'b001,
        PMS_V86    = 3'b011,
        PMS_COMPAT = 3'b010,
        PMS_WIDE   = 3'b110,
        PMS_MGMT   = 3'b111
    } pms_mode_e;

    // saved context for management entry
    typedef struct packed {
        pms_mode_e   mode;  // mode at interrupt time
        logic [31:0] ctrl;  // control word zero
        logic [31:0] flags; // flags word
        logic [31:0] efer;  // extended feature enable
    } pms_ctx_s;

    // width summary shown to software
    typedef struct packed {
        logic [7:0] idt_bytes; // interrupt descriptor size
        logic [7:0] reg_width; // flags and control width
        logic [7:0] dbg_width; // debug register width
        logic [2:0] levels;    // translation levels
        logic       task_gate; // task gates allowed
        logic       prio_en;   // priority window reachable
        logic       ident_map; // linear used as physical
        logic [1:0] pad;       // keeps the summary one 32-bit word
    } pms_width_s;

endpackage

// [pms_mgmt_src.sv]
// platform-side driver of the management request pin
`timescale 1ns/1ps
module pms_mgmt_src (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic fire,
    output logic      pin_n
);
    // active low while asked, released high otherwise and in reset
    always_ff @(posedge aclk) begin
        pin_n <= !(aresetn && fire);
    end
endmodule

// [test_pms_mode_seq.sv]
// self-checking bench for the mode sequencer
`timescale 1ns/1ps
module test_pms_mode_seq;
    import pms_pkg::*;
    logic        aclk, aresetn, fire, pin_n, msp, idm;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic        aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
    logic [1:0]  bresp, rresp;
    pms_mode_e   mode;
    logic [33:0] q[$];           // expected {resp, data} per read
    int          num_errors = 0;
    int          n_compared = 0;
    int          cyc = 0;
    pms_mgmt_src u_src (.aclk(aclk), .aresetn(aresetn), .fire(fire),
        .pin_n(pin_n));
    pms_mode_seq u_dut (.aclk(aclk), .aresetn(aresetn),
        .mgmt_interrupt_pin_n(pin_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
        .s_axi_bresp(bresp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
        .s_axi_araddr(araddr), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(r_v),
        .s_axi_rready(r_r), .mode_reg(mode), .mgmt_space_reg(msp),
        .identity_map_reg(idm));
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    task automatic chk(input logic [33:0] s, input logic [33:0] e);
        n_compared++;
        if (s !== e) begin
            num_errors++;
            $display("Error %0t: got %h want %h", $time, s, e);
        end
    endtask
    task final_report;
        if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // read monitor pops the oldest note; timeout guards hangs
    always @(posedge aclk) begin
        cyc++;
        if (cyc > 3000) begin
            num_errors++;
            final_report();
        end else if (r_v && r_r) begin
            chk({rresp, rdata}, q.pop_front());
        end
    end
    // both channels offered together, each dropped when taken
    task wrt(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_r <= 1'b1;
        do begin
            @(posedge aclk);
            if (aw_r) aw_v <= 1'b0;
            if (w_r) w_v <= 1'b0;
        end while (!b_v);
        chk(34'(bresp), (a == PMS_MODE_OFF) ? 34'(PMS_RESP_ERR)
            : 34'(PMS_RESP_OK));
        b_r <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge aclk);
        q.push_back(e);
        araddr <= a;
        ar_v <= 1'b1;
        r_r <= 1'b1;
        do begin
            @(posedge aclk);
            if (ar_r) ar_v <= 1'b0;
        end while (!r_v);
        r_r <= 1'b0;
    endtask
    // bounded wait for the mode to settle, then compare
    task wm(input pms_mode_e m);
        repeat (8) if (mode !== m) @(posedge aclk);
        chk(34'(mode), 34'(m));
    endtask
    initial begin
        {aresetn, fire, aw_v, w_v, b_r, ar_v, r_r} = 7'h00;
        {awaddr, araddr, wdata} = 48'h0;
        v = $urandom(32'h8ca06f1a);
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        wm(PMS_REAL);
        chk(34'(idm), 34'h1);
        wrt(PMS_MODE_OFF, 32'h0000_0007);
        wrt(PMS_FLAGS_OFF, 32'h0002_0000);
        repeat (3) @(posedge aclk);
        chk(34'(mode), 34'(PMS_REAL));
        wrt(PMS_CTRL_OFF, 32'h0000_0001);
        wm(PMS_V86);
        wrt(PMS_FLAGS_OFF, 32'h0);
        wm(PMS_PROT);
        wrt(PMS_EFER_OFF, 32'h0000_0100);
        wrt(PMS_CSEG_OFF, 32'h1);
        wrt(PMS_CTRL_OFF, 32'h8000_0001);
        wm(PMS_WIDE);
        chk(34'(idm), 34'h0);
        rd(PMS_EFER_OFF, {PMS_RESP_OK, 32'h0000_0500});
        wrt(PMS_FLAGS_OFF, 32'h0002_0000);
        rd(PMS_FLAGS_OFF, {PMS_RESP_OK, 32'h0});
        wrt(PMS_CSEG_OFF, 32'h0);
        wm(PMS_COMPAT);
        v = $urandom & 32'hF;
        wrt(PMS_PRIO_OFF, v);
        rd(PMS_PRIO_OFF, {PMS_RESP_OK, v});
        v = $urandom;
        wrt(PMS_ROOT_OFF, v);
        rd(PMS_ROOT_OFF, {PMS_RESP_OK, v});
        rd(PMS_WIDTH_OFF, {PMS_RESP_OK, PMS_IDT_LONG, PMS_W64, PMS_W64,
            PMS_LVL_LONG, 5'b01000});
        fire <= 1'b1;
        wm(PMS_MGMT);
        chk(34'(msp), 34'h1);
        rd(PMS_SAVE_OFF, {PMS_RESP_OK, 29'h0, PMS_COMPAT});
        rd(PMS_MODE_OFF, {PMS_RESP_OK, 29'h0, PMS_MGMT});
        fire <= 1'b0;
        wrt(PMS_CTRL_OFF, 32'h0);
        wrt(PMS_RESUME_OFF, 32'h0);
        wm(PMS_COMPAT);
        rd(PMS_CTRL_OFF, {PMS_RESP_OK, 32'h8000_0001});
        chk(34'(msp), 34'h0);
        rd(8'h3C, {PMS_RESP_ERR, 32'h0});
        @(posedge aclk);
        final_report();
    end
endmodule
